// ---- design/idq_map.svh ----
`ifndef IDQ_MAP_SVH
`define IDQ_MAP_SVH
// Register offsets on the plain register port
`define IDQ_OFS_RES_A 8'h00
`define IDQ_OFS_RES_B 8'h04
`define IDQ_OFS_RES_C 8'h08
`define IDQ_OFS_RES_D 8'h0c
`define IDQ_OFS_EXEC 8'h10
`define IDQ_OFS_FLAGS 8'h14
`define IDQ_OFS_VERSION 8'h18
`define IDQ_OFS_FEATURE 8'h1c
`define IDQ_OFS_DESC 8'h20
// Reset values
`define IDQ_FLAGS_RST 32'h0000_0000
`define IDQ_VERSION_RST 14'h0000
`define IDQ_FEATURE_RST 32'h0000_0000
// Leaf answers
`define IDQ_MAX_LEAF 32'h0000_0002
`define IDQ_L2_WORD_A 32'h0302_0101
`define IDQ_L2_WORD_B 32'h0000_0000
`define IDQ_L2_WORD_C 32'h0000_0000
`define IDQ_L2_WORD_D 32'h0604_0a42
`define IDQ_L2_REPEAT 8'h01
`define IDQ_VALID_BIT 31
// Version word fields
`define IDQ_STEP_MSB 3
`define IDQ_STEP_LSB 0
`define IDQ_MODEL_MSB 7
`define IDQ_MODEL_LSB 4
`define IDQ_FAMILY_MSB 11
`define IDQ_FAMILY_LSB 8
`define IDQ_TYPE_MSB 13
`define IDQ_TYPE_LSB 12
// Control and status bits
`define IDQ_FLAG_IDS_BIT 0
`define IDQ_EXEC_BUSY_BIT 0
// Timing: fetch steps and cycles from start strobe to done
`define IDQ_FETCH_LAST 3'h4
`define IDQ_START_TO_DONE 6
// Descriptor info word fields
`define IDQ_DI_KIND_LSB 0
`define IDQ_DI_WAYS_LSB 4
`define IDQ_DI_LINE_LSB 8
`define IDQ_DI_SIZE_LSB 16
`define IDQ_DI_PAGE4M_BIT 15
`endif

// ---- design/idq_pkg.sv ----
package idq_pkg;
  // Sequencer states
  typedef enum logic [1:0] {idq_idle, idq_fetch} idq_state_t;
  // Descriptor kinds
  typedef enum logic [3:0] {
    idq_kind_null, idq_kind_itlb, idq_kind_dtlb, idq_kind_icache,
    idq_kind_dcache, idq_kind_unified, idq_kind_unknown
  } idq_kind_t;
endpackage : idq_pkg

// ---- design/idq_resp_rom.sv ----
`timescale 1ns/10ps
`include "idq_map.svh"
module idq_resp_rom #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 12,
  parameter int ADDR_W = 4,
  parameter logic [31:0] VENDOR_B = 32'h6162_6364,
  parameter logic [31:0] VENDOR_C = 32'h6566_6768,
  parameter logic [31:0] VENDOR_D = 32'h696a_6b6c
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] addr,
  output logic [WIDTH-1:0] rd_data
);
  import idq_pkg::*;
  typedef struct packed {logic [WIDTH-1:0] data;} idq_rom_st_t;
  idq_rom_st_t cur_reg;
  idq_rom_st_t cur_next;

  // Table layout is fixed at one 32-bit word per entry
  if (WIDTH != 32 || DEPTH > (1 << ADDR_W) || DEPTH < 12) begin : g_bad
    $error("idq_resp_rom: unsupported WIDTH, DEPTH or ADDR_W");
  end

  // Address is {leaf, word}; word 0..3 is A, B, C, D
  function automatic logic [WIDTH-1:0] word_at(input logic [ADDR_W-1:0] a);
    logic [WIDTH-1:0] w;
    w = '0;
    unique case (a[3:0])
      4'h0: w = `IDQ_MAX_LEAF;
      4'h1: w = VENDOR_B;
      4'h2: w = VENDOR_C;
      4'h3: w = VENDOR_D;
      4'h8: w = `IDQ_L2_WORD_A;
      4'h9: w = `IDQ_L2_WORD_B;
      4'ha: w = `IDQ_L2_WORD_C;
      4'hb: w = `IDQ_L2_WORD_D;
      default: w = '0;
    endcase
    return w;
  endfunction : word_at

  // Registered read port
  always_comb begin
    cur_next = cur_reg;
    cur_next.data = srst ? '0 : word_at(addr);
  end

  always_ff @(posedge clock) begin
    cur_reg <= cur_next;
  end

  assign rd_data = cur_reg.data;
endmodule : idq_resp_rom

// ---- design/idq_desc_decode.sv ----
`timescale 1ns/10ps
`include "idq_map.svh"
module idq_desc_decode (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] code,
  output logic [31:0] info
);
  import idq_pkg::*;
  typedef struct packed {logic [31:0] info;} idq_dec_st_t;
  idq_dec_st_t cur_reg;
  idq_dec_st_t cur_next;

  // Pack kind, ways, line bytes, size and page flag into one word
  function automatic logic [31:0] pack(input idq_kind_t k,
      input logic [3:0] ways, input logic [7:0] line,
      input logic [15:0] size, input logic page4m);
    logic [31:0] w;
    w = '0;
    w[`IDQ_DI_KIND_LSB +: 4] = k;
    w[`IDQ_DI_WAYS_LSB +: 4] = ways;
    w[`IDQ_DI_LINE_LSB +: 7] = line[6:0];
    w[`IDQ_DI_PAGE4M_BIT] = page4m;
    w[`IDQ_DI_SIZE_LSB +: 16] = size;
    return w;
  endfunction : pack

  // Descriptor table; TLB size is entries, cache size is kbytes
  function automatic logic [31:0] decode(input logic [7:0] c);
    logic [31:0] w;
    w = '0;
    unique case (c)
      8'h00: w = pack(idq_kind_null, 4'h0, 8'h00, 16'h0000, 1'b0);
      8'h01: w = pack(idq_kind_itlb, 4'h4, 8'h00, 16'h0040, 1'b0);
      8'h02: w = pack(idq_kind_itlb, 4'h4, 8'h00, 16'h0004, 1'b1);
      8'h03: w = pack(idq_kind_dtlb, 4'h4, 8'h00, 16'h0040, 1'b0);
      8'h04: w = pack(idq_kind_dtlb, 4'h4, 8'h00, 16'h0008, 1'b1);
      8'h06: w = pack(idq_kind_icache, 4'h4, 8'h20, 16'h0008, 1'b0);
      8'h0a: w = pack(idq_kind_dcache, 4'h2, 8'h20, 16'h0008, 1'b0);
      8'h41: w = pack(idq_kind_unified, 4'h4, 8'h20, 16'h0080, 1'b0);
      8'h42: w = pack(idq_kind_unified, 4'h4, 8'h20, 16'h0100, 1'b0);
      8'h43: w = pack(idq_kind_unified, 4'h4, 8'h20, 16'h0200, 1'b0);
      default: w = pack(idq_kind_unknown, 4'h0, 8'h00, 16'h0000, 1'b0);
    endcase
    return w;
  endfunction : decode

  // Registered decode
  always_comb begin
    cur_next = cur_reg;
    cur_next.info = srst ? '0 : decode(code);
  end

  always_ff @(posedge clock) begin
    cur_reg <= cur_next;
  end

  assign info = cur_reg.info;
endmodule : idq_desc_decode

// ---- design/idq_top.sv ----
`timescale 1ns/10ps
`include "idq_map.svh"
module idq_top #(
  parameter logic [31:0] VENDOR_B = 32'h6162_6364, // Arbitrary value
  parameter logic [31:0] VENDOR_C = 32'h6566_6768, // Arbitrary value
  parameter logic [31:0] VENDOR_D = 32'h696a_6b6c // Arbitrary value
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output logic busy,
  output logic done
);
  import idq_pkg::*;

  typedef struct packed {
    idq_state_t st;
    logic [2:0] cnt;
    logic [1:0] leaf;
    logic in_range;
    logic [31:0] res_a;
    logic [31:0] res_b;
    logic [31:0] res_c;
    logic [31:0] res_d;
    logic [2:0][31:0] stage;
    logic [31:0] flags;
    logic [13:0] version;
    logic [31:0] feature;
    logic [7:0] desc_code;
    logic [31:0] rd_data;
    logic busy;
    logic done;
  } idq_core_st_t;

  idq_core_st_t cur_reg;
  idq_core_st_t cur_next;
  logic [3:0] rom_addr;
  logic [31:0] rom_data;
  logic [31:0] desc_info;
  logic start_evt;

  // Response table walked one word per cycle
  assign rom_addr = {cur_reg.leaf, cur_reg.cnt[1:0]};

  idq_resp_rom #(
    .WIDTH(32),
    .DEPTH(12),
    .ADDR_W(4),
    .VENDOR_B(VENDOR_B),
    .VENDOR_C(VENDOR_C),
    .VENDOR_D(VENDOR_D)
  ) u_rom (
    .clock(clock),
    .srst(srst),
    .addr(rom_addr),
    .rd_data(rom_data)
  );

  // Descriptor lookup for software
  idq_desc_decode u_dec (
    .clock(clock),
    .srst(srst),
    .code(cur_reg.desc_code),
    .info(desc_info)
  );

  // Final word for one result register of the sampled leaf
  function automatic logic [31:0] final_word(input logic in_range,
      input logic [1:0] leaf, input logic [1:0] idx,
      input logic [31:0] rom_word, input logic [13:0] version,
      input logic [31:0] feature);
    logic [31:0] w;
    w = rom_word;
    if (!in_range) begin
      w = '0;
    end else if (leaf == 2'h1) begin
      unique case (idx)
        2'h0: w = {18'h00000, version};
        2'h3: w = feature;
        default: w = '0;
      endcase
    end else if (leaf == 2'h2) begin
      w = rom_word;
      w[`IDQ_VALID_BIT] = 1'b0;
    end
    return w;
  endfunction : final_word

  // Execute request accepted only when idle
  assign start_evt = wr_en && (addr == `IDQ_OFS_EXEC) &&
    (cur_reg.st == idq_idle);

  // Register port, sequencer and read mux
  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    // Software writes to control registers
    if (wr_en) begin
      unique case (addr)
        `IDQ_OFS_RES_A: cur_next.res_a = wr_data;
        `IDQ_OFS_FLAGS: cur_next.flags = wr_data;
        `IDQ_OFS_VERSION: cur_next.version = wr_data[13:0];
        `IDQ_OFS_FEATURE: cur_next.feature = wr_data;
        `IDQ_OFS_DESC: cur_next.desc_code = wr_data[7:0];
        default: begin
        end
      endcase
    end
    // Sequencer
    unique case (cur_reg.st)
      idq_idle: begin
        if (start_evt) begin
          cur_next.st = idq_fetch;
          cur_next.cnt = 3'h0;
          cur_next.leaf = cur_reg.res_a[1:0];
          cur_next.in_range = cur_reg.res_a <= `IDQ_MAX_LEAF;
          cur_next.busy = 1'b1;
        end
      end
      idq_fetch: begin
        cur_next.cnt = cur_reg.cnt + 3'h1;
        if (cur_reg.cnt != 3'h0 && cur_reg.cnt != `IDQ_FETCH_LAST) begin
          cur_next.stage[cur_reg.cnt[1:0] - 2'h1] = rom_data;
        end
        if (cur_reg.cnt == `IDQ_FETCH_LAST) begin
          // All four results land in the same edge
          cur_next.res_a = final_word(cur_reg.in_range, cur_reg.leaf,
            2'h0, cur_reg.stage[0], cur_reg.version,
            cur_reg.feature);
          cur_next.res_b = final_word(cur_reg.in_range, cur_reg.leaf,
            2'h1, cur_reg.stage[1], cur_reg.version, cur_reg.feature);
          cur_next.res_c = final_word(cur_reg.in_range, cur_reg.leaf,
            2'h2, cur_reg.stage[2], cur_reg.version, cur_reg.feature);
          cur_next.res_d = final_word(cur_reg.in_range, cur_reg.leaf,
            2'h3, rom_data, cur_reg.version, cur_reg.feature);
          cur_next.st = idq_idle;
          cur_next.busy = 1'b0;
          cur_next.done = 1'b1;
        end
      end
    endcase
    // Read data valid in the cycle after the strobe
    cur_next.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        `IDQ_OFS_RES_A: cur_next.rd_data = cur_reg.res_a;
        `IDQ_OFS_RES_B: cur_next.rd_data = cur_reg.res_b;
        `IDQ_OFS_RES_C: cur_next.rd_data = cur_reg.res_c;
        `IDQ_OFS_RES_D: cur_next.rd_data = cur_reg.res_d;
        `IDQ_OFS_EXEC: cur_next.rd_data = {31'h00000000, cur_reg.busy};
        `IDQ_OFS_FLAGS: cur_next.rd_data = cur_reg.flags;
        `IDQ_OFS_VERSION: cur_next.rd_data = {18'h00000, cur_reg.version};
        `IDQ_OFS_FEATURE: cur_next.rd_data = cur_reg.feature;
        `IDQ_OFS_DESC: cur_next.rd_data = desc_info;
        default: cur_next.rd_data = '0;
      endcase
    end
    // Synchronous reset
    if (srst) begin
      cur_next = '0;
      cur_next.st = idq_idle;
      cur_next.flags = `IDQ_FLAGS_RST;
      cur_next.version = `IDQ_VERSION_RST;
      cur_next.feature = `IDQ_FEATURE_RST;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    cur_reg <= cur_next;
  end

  // Outputs straight from flops
  assign rd_data = cur_reg.rd_data;
  assign busy = cur_reg.busy;
  assign done = cur_reg.done;

  // Checks on the answers and the sequencing
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  logic leaf_ok;
  assign leaf_ok = done && cur_reg.in_range;

  a_leaf0_max_leaf: assert property (
    leaf_ok && cur_reg.leaf == 2'h0 |-> cur_reg.res_a == `IDQ_MAX_LEAF)
    else $error("leaf 0 highest leaf value wrong");

  a_leaf0_vendor_words: assert property (
    leaf_ok && cur_reg.leaf == 2'h0 |-> cur_reg.res_b == VENDOR_B &&
    cur_reg.res_c == VENDOR_C && cur_reg.res_d == VENDOR_D)
    else $error("leaf 0 vendor string wrong");

  a_leaf1_version_fields: assert property (
    leaf_ok && cur_reg.leaf == 2'h1 |->
    cur_reg.res_a[`IDQ_STEP_MSB:`IDQ_STEP_LSB] ==
    $past(cur_reg.version[3:0]) &&
    cur_reg.res_a[`IDQ_MODEL_MSB:`IDQ_MODEL_LSB] ==
    $past(cur_reg.version[7:4]) &&
    cur_reg.res_a[`IDQ_FAMILY_MSB:`IDQ_FAMILY_LSB] ==
    $past(cur_reg.version[11:8]) &&
    cur_reg.res_a[`IDQ_TYPE_MSB:`IDQ_TYPE_LSB] ==
    $past(cur_reg.version[13:12]) &&
    cur_reg.res_a[31:14] == 18'h00000)
    else $error("leaf 1 version layout wrong");

  a_leaf1_feature_word: assert property (
    leaf_ok && cur_reg.leaf == 2'h1 |->
    cur_reg.res_d == $past(cur_reg.feature) &&
    cur_reg.res_b == 32'h0 && cur_reg.res_c == 32'h0)
    else $error("leaf 1 feature or reserved words wrong");

  a_leaf2_table_words: assert property (
    leaf_ok && cur_reg.leaf == 2'h2 |-> cur_reg.res_a == `IDQ_L2_WORD_A &&
    cur_reg.res_b == `IDQ_L2_WORD_B && cur_reg.res_c == `IDQ_L2_WORD_C &&
    cur_reg.res_d == `IDQ_L2_WORD_D)
    else $error("leaf 2 descriptor words wrong");

  a_leaf2_repeat_count: assert property (
    leaf_ok && cur_reg.leaf == 2'h2 |-> cur_reg.res_a[7:0] == `IDQ_L2_REPEAT)
    else $error("leaf 2 repeat count wrong");

  a_leaf2_valid_bits: assert property (
    leaf_ok && cur_reg.leaf == 2'h2 |-> !cur_reg.res_a[`IDQ_VALID_BIT] &&
    !cur_reg.res_b[`IDQ_VALID_BIT] && !cur_reg.res_c[`IDQ_VALID_BIT] &&
    !cur_reg.res_d[`IDQ_VALID_BIT])
    else $error("leaf 2 valid bit set");

  a_range_zero_fill: assert property (
    done && !cur_reg.in_range |-> cur_reg.res_a == 32'h0 &&
    cur_reg.res_b == 32'h0 && cur_reg.res_c == 32'h0 &&
    cur_reg.res_d == 32'h0)
    else $error("out of range leaf not zero filled");

  a_start_done_timing: assert property (
    start_evt |=> busy [*5] ##1 (done && !busy))
    else $error("start to done timing wrong");

  a_leaf_sampled_start: assert property (
    start_evt |=> cur_reg.leaf == $past(cur_reg.res_a[1:0]) &&
    cur_reg.in_range == ($past(cur_reg.res_a) <= `IDQ_MAX_LEAF))
    else $error("leaf not sampled at start");

  a_results_hold_busy: assert property (
    busy && $past(busy) |-> $stable(cur_reg.res_b) &&
    $stable(cur_reg.res_c) && $stable(cur_reg.res_d))
    else $error("results changed before commit");

  a_flag_set_clear: assert property (
    wr_en && addr == `IDQ_OFS_FLAGS |=>
    cur_reg.flags[`IDQ_FLAG_IDS_BIT] == $past(wr_data[`IDQ_FLAG_IDS_BIT]))
    else $error("support flag not writable");

  a_desc_decode_l2: assert property (
    wr_en && addr == `IDQ_OFS_DESC && wr_data[7:0] == 8'h42 ##1
    !(wr_en && addr == `IDQ_OFS_DESC) |=>
    desc_info[`IDQ_DI_SIZE_LSB +: 16] == 16'h0100 &&
    desc_info[`IDQ_DI_LINE_LSB +: 7] == 7'h20)
    else $error("descriptor 42 decode wrong");

  a_desc_decode_tlb: assert property (
    wr_en && addr == `IDQ_OFS_DESC && wr_data[7:0] == 8'h04 ##1
    !(wr_en && addr == `IDQ_OFS_DESC) |=>
    desc_info[`IDQ_DI_SIZE_LSB +: 16] == 16'h0008 &&
    desc_info[`IDQ_DI_PAGE4M_BIT])
    else $error("descriptor 04 decode wrong");

  // Register port replies
  a_read_reply_window: assert property (
    !$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside the reply cycle");

  a_read_result_a: assert property (
    rd_en && addr == `IDQ_OFS_RES_A |=> rd_data == $past(cur_reg.res_a))
    else $error("result A read back wrong");

  a_read_status_busy: assert property (
    rd_en && addr == `IDQ_OFS_EXEC |=> rd_data == {31'h0, $past(busy)})
    else $error("status read does not show busy");

  a_read_flags_back: assert property (
    rd_en && addr == `IDQ_OFS_FLAGS |=> rd_data == $past(cur_reg.flags))
    else $error("flags register read back wrong");

  a_read_unmapped_zero: assert property (
    rd_en && addr > `IDQ_OFS_DESC |=> rd_data == 32'h0)
    else $error("unmapped read not zero");

  // Sequencer guards
  a_busy_done_apart: assert property (
    !(busy && done))
    else $error("busy and done high together");

  a_exec_busy_ignored: assert property (
    busy && wr_en && addr == `IDQ_OFS_EXEC |=> $stable(cur_reg.leaf) &&
    $stable(cur_reg.in_range))
    else $error("start accepted while busy");

  a_results_ro_write: assert property (
    wr_en && !busy && (addr == `IDQ_OFS_RES_B ||
    addr == `IDQ_OFS_RES_C || addr == `IDQ_OFS_RES_D) |=>
    $stable(cur_reg.res_b) && $stable(cur_reg.res_c) &&
    $stable(cur_reg.res_d))
    else $error("read-only result register written");

  // Descriptor lookups, two cycles after the code is written
  a_desc_decode_null: assert property (
    wr_en && addr == `IDQ_OFS_DESC && wr_data[7:0] == 8'h00 |=> ##1
    desc_info == 32'h0)
    else $error("descriptor 00 decode wrong");

  a_desc_decode_itlb: assert property (
    wr_en && addr == `IDQ_OFS_DESC && wr_data[7:0] == 8'h01 |=> ##1
    desc_info[`IDQ_DI_SIZE_LSB +: 16] == 16'h0040 &&
    desc_info[`IDQ_DI_WAYS_LSB +: 4] == 4'h4 &&
    !desc_info[`IDQ_DI_PAGE4M_BIT])
    else $error("descriptor 01 decode wrong");

  a_desc_decode_dcache: assert property (
    wr_en && addr == `IDQ_OFS_DESC && wr_data[7:0] == 8'h0a |=> ##1
    desc_info[`IDQ_DI_SIZE_LSB +: 16] == 16'h0008 &&
    desc_info[`IDQ_DI_WAYS_LSB +: 4] == 4'h2 &&
    desc_info[`IDQ_DI_LINE_LSB +: 7] == 7'h20)
    else $error("descriptor 0a decode wrong");

  a_desc_decode_other: assert property (
    wr_en && addr == `IDQ_OFS_DESC && wr_data[7:0] == 8'h05 |=> ##1
    desc_info[`IDQ_DI_KIND_LSB +: 4] == idq_kind_unknown)
    else $error("unlisted descriptor not marked unknown");

  c_leaf0_commit: cover property (leaf_ok && cur_reg.leaf == 2'h0);
  c_leaf2_commit: cover property (leaf_ok && cur_reg.leaf == 2'h2);
  c_out_of_range: cover property (done && !cur_reg.in_range);
  c_back_to_back: cover property (done ##1 start_evt);
  c_busy_retry: cover property (busy && wr_en && addr == `IDQ_OFS_EXEC);
endmodule : idq_top

// ---- test/idq_top_bench.sv ----
`timescale 1ns/10ps
`include "idq_map.svh"
module idq_top_bench;
  import idq_pkg::*;
  localparam logic [31:0] VEND_B = 32'h1357_2468; // Arbitrary value
  localparam logic [31:0] VEND_C = 32'h2468_1357; // Arbitrary value
  localparam logic [31:0] VEND_D = 32'h0f1e_2d3c; // Arbitrary value
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic busy;
  logic done;
  int failures = 0;
  int checks = 0;
  logic [31:0] seed = 32'h0000_5f9a; // Fixed seed, 24474
  logic [31:0] rv, vers, feat, lv [6];
  logic [7:0] cv [12];
  // Clock, 10 ns period
  always #5 clock = ~clock;
  idq_top #(
    .VENDOR_B(VEND_B),
    .VENDOR_C(VEND_C),
    .VENDOR_D(VEND_D)
  ) idq_top_inst (
    .clock(clock),
    .srst(srst),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .busy(busy),
    .done(done)
  );
  // Xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Expected result word k (A, B, C, D) for a leaf
  function automatic logic [31:0] exp_res(input logic [31:0] leaf,
                                          input int k);
    logic [31:0] w [4];
    if (leaf == 32'h0) w = '{32'h2, VEND_B, VEND_C, VEND_D};
    else if (leaf == 32'h1) w = '{{18'h0, vers[13:0]}, 32'h0, 32'h0, feat};
    else if (leaf == 32'h2) w = '{32'h0302_0101, 32'h0, 32'h0, 32'h0604_0a42};
    else w = '{default: 32'h0};
    return w[k];
  endfunction : exp_res
  // Expected decoded descriptor: size, 4M flag, line, ways, kind
  function automatic logic [31:0] desc_exp(input logic [7:0] c);
    case (c)
      8'h00: return 32'h0;
      8'h01: return {16'h0040, 1'b0, 7'h00, 4'h4, 4'h1};
      8'h02: return {16'h0004, 1'b1, 7'h00, 4'h4, 4'h1};
      8'h03: return {16'h0040, 1'b0, 7'h00, 4'h4, 4'h2};
      8'h04: return {16'h0008, 1'b1, 7'h00, 4'h4, 4'h2};
      8'h06: return {16'h0008, 1'b0, 7'h20, 4'h4, 4'h3};
      8'h0a: return {16'h0008, 1'b0, 7'h20, 4'h2, 4'h4};
      8'h41: return {16'h0080, 1'b0, 7'h20, 4'h4, 4'h5};
      8'h42: return {16'h0100, 1'b0, 7'h20, 4'h4, 4'h5};
      8'h43: return {16'h0200, 1'b0, 7'h20, 4'h4, 4'h5};
      default: return 32'h6;
    endcase
  endfunction : desc_exp
  // Fields that carry meaning for each kind of descriptor
  function automatic logic [31:0] desc_mask(input logic [31:0] e);
    if (e[3:0] == 4'h1 || e[3:0] == 4'h2) return 32'hffff_80ff;
    if (e[3:0] >= 4'h3 && e[3:0] <= 4'h5) return 32'hffff_ffff;
    return 32'h0000_000f;
  endfunction : desc_mask
  // Compare tasks
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32
  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge clock);
    #1 check32(rd_data, 32'h0);
  endtask : rd
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check32(d, exp);
  endtask : rdchk
  // One query; poke retries start and rewrites A while busy
  task automatic query(input logic [31:0] leaf, input bit poke);
    int i;
    wr(`IDQ_OFS_RES_A, leaf);
    wr(`IDQ_OFS_EXEC, rnd());
    for (i = 1; i <= 6; i++) begin
      if (i > 1) @(posedge clock);
      if (poke && i == 2) begin
        addr <= `IDQ_OFS_EXEC;
        wr_en <= 1'b1;
      end
      if (poke && i == 3) begin
        addr <= `IDQ_OFS_RES_A;
        wr_data <= ~leaf;
      end
      if (poke && i == 4) wr_en <= 1'b0;
      #1;
      check_bit(busy, i < 6);
      check_bit(done, i == 6);
    end
    @(posedge clock);
    #1 check_bit(done, 1'b0);
    check_bit(busy, 1'b0);
  endtask : query
  task automatic check_res(input logic [31:0] leaf);
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      rd(8'(k * 4), d);
      check32(d, exp_res(leaf, k));
    end
  endtask : check_res
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    check_res(32'h0000_0003);
    rdchk(`IDQ_OFS_FLAGS, 32'h0);
    rdchk(8'h40, 32'h0);
    lv = '{32'h1, 32'h0, rnd(), 32'hffff_ffff, 32'h0, 32'h1};
    foreach (lv[j]) begin
      wr(`IDQ_OFS_FLAGS, lv[j]);
      rdchk(`IDQ_OFS_FLAGS, lv[j]);
    end
    vers = rnd() & 32'h0000_3fff;
    feat = rnd();
    wr(`IDQ_OFS_VERSION, vers);
    wr(`IDQ_OFS_FEATURE, feat);
    query(32'h0, 1'b0);
    check_res(32'h0);
    query(32'h1, 1'b1);
    check_res(32'h1);
    query(32'h2, 1'b1);
    check_res(32'h2);
    wr(`IDQ_OFS_RES_B, rnd());
    rdchk(`IDQ_OFS_RES_B, 32'h0);
    // Leaves above the maximum, low two bits hiding a valid leaf except in 3 and ffffffff
    lv = '{32'h3, 32'h4, 32'h100, 32'h8000_0002, 32'hffff_ffff, rnd() | 32'h4};
    foreach (lv[j]) begin
      query(lv[j], 1'b0);
      check_res(lv[j]);
    end
    // Random mix of leaves and fields
    for (int n = 0; n < 8; n++) begin
      rv = rnd();
      if (rv[1:0] == 2'd1) begin
        vers = rnd() & 32'h0000_3fff;
        feat = rnd();
        wr(`IDQ_OFS_VERSION, vers);
        wr(`IDQ_OFS_FEATURE, feat);
      end
      if (!rv[4]) rv = {30'h0, rv[1:0]};
      query(rv, rv[5]);
      check_res(rv);
    end
    // Mid-run reset clears results and software registers
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    check_res(32'h3);
    rdchk(`IDQ_OFS_FLAGS, 32'h0);
    vers = 32'h0;
    feat = 32'h0;
    query(32'h1, 1'b0);
    check_res(32'h1);
    // Descriptor codes, listed ones, unlisted 05 and ff, then random bytes
    cv = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h0a, 8'h41, 8'h42,
           8'h43, 8'h05, 8'hff};
    for (int n = 0; n < 20; n++) begin
      rv = (n < 12) ? {24'h0, cv[n]} : rnd();
      wr(`IDQ_OFS_DESC, {rnd() & 32'hffff_ff00} | {24'h0, rv[7:0]});
      rd(`IDQ_OFS_DESC, feat);
      check32(feat & desc_mask(desc_exp(rv[7:0])),
              desc_exp(rv[7:0]));
    end
    test_done();
  end
endmodule : idq_top_bench
